// file: rtl/display_serializer.sv
/*
  Display link serializer: captures the 28-bit parallel word each parallel
  clock, serialises it on four data lanes plus a clock lane at seven bits per
  clock, controls power-down and missing-clock output states.
  Assumes bit_clk is a PLL output at seven times the parallel clock, locked
  in phase, and ref_clk is a free-running 100 MHz supervisor clock.
*/
// Behaviour
// [R1] All 28 parallel bits are captured every input clock and sent on four lanes.
// [R2] Each lane shifts seven bits per input clock, so runs at seven times its rate.
// [R3] A fifth lane carries a clock copy aligned with the data lanes.
// [R4] Bits 0..23 are colour, 24..26 line sync, frame sync, data valid; 27 spare.
// [R5] A strobe select input picks the rising or falling capture edge.
// [R6] With power-down high and the input clock missing, every output drives low.
// [R7] With power-down low, every output is high impedance and sending stops.
// [R8] Any order of clock, data and power-down application works.
// [R9] The source supplies an input clock of 18 to 87.5 MHz.
// [R10] The multiplier tracks spread-spectrum input up to 100 kHz, 2.5 or 5 percent.
// [R11] Power-down pulses last at least one microsecond.
// [R12] The input clock high time is 0.35 to 0.65 of its period.
// [R13] Bits map to lanes and slots by a fixed table, slots sent in fixed order.
`timescale 1ns/1ns
`include "serializer_params.svh"
module display_serializer
  import serializer_pkg::*;
#(
  parameter int LOSS_CYCLES = `CLK_LOSS_CYCLES,
  parameter int PD_CYCLES = `PD_MIN_CYCLES
)(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic parallel_clock_in,
  input wire logic bit_clk,
  input wire serializer_pkg::par_word_t parallel_data_in,
  input wire logic strobe_rising,
  input wire logic power_down_n,
  output logic [`LANE_COUNT-1:0] lane_data,
  output logic [`LANE_COUNT-1:0] lane_data_oe,
  output logic lane_clock,
  output logic lane_clock_oe
);
  import serializer_pkg::*;

  initial
  begin
    if (LOSS_CYCLES < 2 || PD_CYCLES < 4)
      $error("display_serializer count parameters out of range");
  end

  // ---------------- Capture in the parallel clock domain ----------------
  par_word_t rise_word_reg, fall_word_reg, cap_word_reg;
  logic cap_toggle_reg;

  // Rising and falling captures; the strobe select picks one (see [R5])
  always_ff @(posedge parallel_clock_in or negedge reset_n)
  begin
    if (!reset_n)
      rise_word_reg <= '0;
    else
      rise_word_reg <= parallel_data_in; // see [R1]
  end

  always_ff @(negedge parallel_clock_in or negedge reset_n)
  begin
    if (!reset_n)
      fall_word_reg <= '0;
    else
      fall_word_reg <= parallel_data_in;
  end

  wire par_word_t chosen_word = strobe_rising ? rise_word_reg : fall_word_reg; // see [R5]

  // Hold a stable copy and mark each parallel cycle with a toggle
  always_ff @(posedge parallel_clock_in or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cap_word_reg <= '0;
      cap_toggle_reg <= 1'b0;
    end
    else
    begin
      cap_word_reg <= chosen_word;
      cap_toggle_reg <= ~cap_toggle_reg;
    end
  end

  // ---------------- Supervisor in the ref_clk domain ----------------
  logic [2:0] tog_sync_reg;
  logic [1:0] pd_sync_reg;
  logic [$clog2(LOSS_CYCLES+1)-1:0] loss_cnt_reg;
  logic [$clog2(PD_CYCLES+1)-1:0] pd_cnt_reg;
  logic clk_present_reg, pd_active_reg;
  out_state_e state_reg, state_next;

  // Two-flop synchronisers; edge detect reads only flops two and three
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_sync_reg <= '0;
      pd_sync_reg <= '0;
    end
    else
    begin
      tog_sync_reg <= {tog_sync_reg[1:0], cap_toggle_reg};
      pd_sync_reg <= {pd_sync_reg[0], power_down_n};
    end
  end

  wire par_edge_seen = tog_sync_reg[2] ^ tog_sync_reg[1];
  wire pd_req = ~pd_sync_reg[1];
  wire loss_hit = (loss_cnt_reg == ($bits(loss_cnt_reg))'(LOSS_CYCLES));
  wire pd_settled = (pd_cnt_reg == ($bits(pd_cnt_reg))'(PD_CYCLES));

  // Missing-clock watchdog: restarts on each parallel cycle (see [R6])
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loss_cnt_reg <= '0;
      clk_present_reg <= 1'b0;
    end
    else if (par_edge_seen)
    begin
      loss_cnt_reg <= '0;
      clk_present_reg <= 1'b1;
    end
    else if (loss_hit)
      clk_present_reg <= 1'b0;
    else
      loss_cnt_reg <= loss_cnt_reg + 1'b1;
  end

  // Power-down filter: level must persist the minimum pulse (see [R11])
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pd_cnt_reg <= '0;
      pd_active_reg <= 1'b1;
    end
    else if (pd_req == pd_active_reg)
      pd_cnt_reg <= '0;
    else if (pd_settled)
    begin
      pd_cnt_reg <= '0;
      pd_active_reg <= pd_req;
    end
    else
      pd_cnt_reg <= pd_cnt_reg + 1'b1;
  end

  // Output state from power-down and clock presence, any order (see [R8])
  always_comb
  begin
    state_next = OUT_RUN;
    if (pd_active_reg)
      state_next = OUT_OFF; // see [R7]
    else if (!clk_present_reg)
      state_next = OUT_LOW; // see [R6]
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= OUT_OFF;
    else
      state_reg <= state_next;
  end

  // ---------------- Serial side in the bit clock domain ----------------
  logic [2:0] slot_cnt_reg;
  logic [2:0] btog_sync_reg;
  logic [1:0] run_sync_reg, drive_sync_reg;
  logic frame_load_reg;
  par_word_t ser_word_reg;
  slot_t [`LANE_COUNT-1:0] lane_slots;
  logic [`LANE_COUNT-1:0] shift_out;
  logic [`LANE_COUNT-1:0] data_reg, data_oe_reg;
  logic clk_lane_reg, clk_oe_reg;

  // Seven slots per parallel clock; word load aligned to toggle edge (see [R2])
  wire btog_edge = btog_sync_reg[2] ^ btog_sync_reg[1];
  wire slot_last = (slot_cnt_reg == 3'(`SLOTS_PER_LANE - 1));

  always_ff @(posedge bit_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      btog_sync_reg <= '0;
      run_sync_reg <= '0;
      drive_sync_reg <= '0;
    end
    else
    begin
      btog_sync_reg <= {btog_sync_reg[1:0], cap_toggle_reg};
      run_sync_reg <= {run_sync_reg[0], state_reg == OUT_RUN};
      drive_sync_reg <= {drive_sync_reg[0], state_reg != OUT_OFF};
    end
  end

  // Slot counter and word handover; spread clock is tracked by the PLL (see [R10])
  always_ff @(posedge bit_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slot_cnt_reg <= '0;
      frame_load_reg <= 1'b0;
      ser_word_reg <= '0;
    end
    else
    begin
      slot_cnt_reg <= (slot_last || btog_edge) ? 3'h0 : slot_cnt_reg + 3'h1;
      frame_load_reg <= slot_last || btog_edge;
      if (slot_last || btog_edge)
        ser_word_reg <= cap_word_reg; // see [R1]
    end
  end

  // Fixed bit-to-slot map: lane L, slot S carries bit 7*L + (6 - S) (see [R13])
  // Colour in bits 0..23, controls and spare in 24..27 (see [R4])
  for (genvar l = 0; l < `LANE_COUNT; l++)
  begin : g_lane
    for (genvar s = 0; s < `SLOTS_PER_LANE; s++)
    begin : g_slot
      assign lane_slots[l][s] = ser_word_reg[`SLOTS_PER_LANE*l + s];
    end
    lane_shifter #(.SLOTS(`SLOTS_PER_LANE)) u_shift (
      .bit_clk(bit_clk),
      .reset_n(reset_n),
      .load(frame_load_reg),
      .slots(lane_slots[l]),
      .serial_out(shift_out[l])
    );
  end

  wire run_now = run_sync_reg[1];
  wire drive_now = drive_sync_reg[1];
  wire slot_t clk_pattern = `CLK_LANE_PATTERN;
  wire [2:0] clk_slot = (slot_cnt_reg == 3'h0) ? 3'(`SLOTS_PER_LANE - 1) : slot_cnt_reg - 3'h1;

  // Registered pins: data, clock copy and enables (see [R3], [R6], [R7])
  always_ff @(posedge bit_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      data_reg <= '0;
      data_oe_reg <= '0;
      clk_lane_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
    end
    else
    begin
      data_reg <= run_now ? shift_out : '0; // see [R6]
      clk_lane_reg <= run_now & clk_pattern[3'(`SLOTS_PER_LANE - 1) - clk_slot]; // see [R3]
      data_oe_reg <= {`LANE_COUNT{drive_now}}; // see [R7]
      clk_oe_reg <= drive_now;
    end
  end

  assign lane_data = data_reg;
  assign lane_data_oe = data_oe_reg;
  assign lane_clock = clk_lane_reg;
  assign lane_clock_oe = clk_oe_reg;

  // ---------------- Assertions ----------------
  sequence s_pd_req_held;
    pd_req [*4];
  endsequence

  a_off_no_drive: assert property (@(posedge ref_clk) disable iff (!reset_n)
    pd_active_reg |=> state_reg == OUT_OFF) // see [R7]
    else $error("outputs enabled while powered down");

  a_loss_low_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!pd_active_reg && !clk_present_reg) |=> state_reg == OUT_LOW) // see [R6]
    else $error("missing clock did not force low state");

  a_pd_filter_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    ($rose(pd_active_reg) |-> $past(pd_req))) // see [R11]
    else $error("power-down taken without request");

  a_pd_short_ignored: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!pd_active_reg && $rose(pd_req)) ##1 s_pd_req_held |-> !pd_active_reg) // see [R11]
    else $error("power-down taken before minimum pulse");

  a_loss_detect: assert property (@(posedge ref_clk) disable iff (!reset_n)
    loss_hit && !par_edge_seen |=> !clk_present_reg) // see [R6]
    else $error("missing clock not detected");

  a_data_low_off: assert property (@(posedge bit_clk) disable iff (!reset_n)
    !run_now |=> data_reg == '0 && !clk_lane_reg) // see [R6]
    else $error("lane active while not running");

  a_oe_follow: assert property (@(posedge bit_clk) disable iff (!reset_n)
    !drive_now |=> data_oe_reg == '0 && !clk_oe_reg) // see [R7]
    else $error("drivers enabled in power-down");

  a_slot_wrap: assert property (@(posedge bit_clk) disable iff (!reset_n)
    (slot_last && !btog_edge) |=> slot_cnt_reg == 3'h0 && frame_load_reg) // see [R2]
    else $error("slot counter did not wrap after seven slots");

  a_word_loaded: assert property (@(posedge bit_clk) disable iff (!reset_n)
    frame_load_reg |-> ser_word_reg == $past(cap_word_reg)) // see [R1]
    else $error("serial word not taken from capture");
endmodule

// file: rtl/serializer_params.svh
/*
  Constants of the display link serializer: bit layout of the parallel word,
  lane and slot counts, timing figures and derived cycle counts.
  Assumes ref_clk runs at 100 MHz; included by bare name.
*/
`ifndef SERIALIZER_PARAMS_SVH
`define SERIALIZER_PARAMS_SVH

`define PAR_WIDTH 28
`define LANE_COUNT 4
`define SLOTS_PER_LANE 7
`define COLOUR_WIDTH 24
`define LINE_SYNC_BIT 24
`define FRAME_SYNC_BIT 25
`define DATA_VALID_BIT 26
`define SPARE_BIT 27
`define REF_CLK_MHZ 100
`define PAR_CLK_MIN_MHZ 18
`define PAR_CLK_MAX_MHZ_X10 875
// Longest input clock period at 18 MHz, in ns, rounded up
`define PAR_CLK_MAX_PERIOD_NS 56
// Missing clock declared after two longest periods without an edge
`define CLK_LOSS_NS (2 * `PAR_CLK_MAX_PERIOD_NS)
`define CLK_LOSS_CYCLES ((`CLK_LOSS_NS * `REF_CLK_MHZ + 999) / 1000)
// Power-down pulses shorter than this are not honoured, in us
`define PD_MIN_PULSE_US 1
`define PD_MIN_CYCLES (`PD_MIN_PULSE_US * `REF_CLK_MHZ)
// Serial clock lane pattern: high for slots 0..3, low for 4..6
`define CLK_LANE_PATTERN 7'h78

`endif

// file: rtl/serializer_pkg.sv
/*
  Types shared by the display link serializer.
  Assumes the params header for widths.
*/
`include "serializer_params.svh"
package serializer_pkg;
  typedef logic [`PAR_WIDTH-1:0] par_word_t;
  typedef logic [`SLOTS_PER_LANE-1:0] slot_t;
  // Output state: Gray sequence off -> idle-low -> run
  typedef enum logic [1:0] {
    OUT_OFF = 2'b00,
    OUT_LOW = 2'b01,
    OUT_RUN = 2'b11
  } out_state_e;
endpackage

// file: rtl/lane_shifter.sv
/*
  One serial lane: loads seven slots per parallel clock and shifts them out
  msb-first on the bit clock (seven times the parallel clock).
  Assumes the load pulse comes from the bit-clock domain.
*/
`timescale 1ns/1ns
module lane_shifter #(
  parameter int SLOTS = 7
)(
  input wire logic bit_clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [SLOTS-1:0] slots,
  output logic serial_out
);
  logic [SLOTS-1:0] shift_reg;

  initial
  begin
    if (SLOTS < 2)
      $error("lane_shifter needs at least two slots");
  end

  // Load a fresh word or shift one slot each bit clock
  always_ff @(posedge bit_clk or negedge reset_n)
  begin
    if (!reset_n)
      shift_reg <= '0;
    else if (load)
      shift_reg <= slots;
    else
      shift_reg <= {shift_reg[SLOTS-2:0], 1'b0};
  end

  assign serial_out = shift_reg[SLOTS-1];
endmodule

// file: tb/link_receiver.sv
/*
  Behavioural link receiver: deserialises the four data lanes, framed by the
  clock lane pattern, into 28-bit words.
  Assumes lanes change on the rising bit clock; keeps shifting when disabled, with rx_valid held low.
*/
`timescale 1ns/1ns
`include "serializer_params.svh"
module link_receiver (
  input wire logic bit_clk,
  input wire logic [`LANE_COUNT-1:0] lane_data,
  input wire logic lane_clock,
  input wire logic lane_clock_oe,
  output logic [`PAR_WIDTH-1:0] rx_word,
  output logic rx_valid
);
  logic [6:0] sh0 = 7'h00;
  logic [6:0] sh1 = 7'h00;
  logic [6:0] sh2 = 7'h00;
  logic [6:0] sh3 = 7'h00;
  logic [6:0] ck = 7'h00;

  // Sample mid-bit; oldest slot ends in the msb of each group
  always @(negedge bit_clk)
  begin
    sh0 = {sh0[5:0], lane_data[0]};
    sh1 = {sh1[5:0], lane_data[1]};
    sh2 = {sh2[5:0], lane_data[2]};
    sh3 = {sh3[5:0], lane_data[3]};
    ck = {ck[5:0], lane_clock};
    rx_valid <= lane_clock_oe && (ck == `CLK_LANE_PATTERN);
    rx_word <= {sh3, sh2, sh1, sh0};
  end
endmodule

// file: tb/tb_display_serializer.sv
/*
  Self-checking bench of the display serializer: a word queue model compared
  with what the receiver model recovers, plus power-down and lost-clock pins.
  Assumes a 28 ns parallel clock phase locked to a 4 ns bit clock.
*/
`timescale 1ns/1ns
`include "serializer_params.svh"
module tb_display_serializer;
  import serializer_pkg::*;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
  logic ref_clk = 0;
  logic reset_n = 0;
  logic parallel_clock_in = 0;
  logic bit_clk = 0;
  par_word_t parallel_data_in = '0;
  logic strobe_rising = 1;
  logic power_down_n = 0;
  logic [3:0] lane_data;
  logic [3:0] lane_data_oe;
  logic lane_clock;
  logic lane_clock_oe;
  logic [27:0] rx_word;
  logic rx_valid;
  logic link_run = 1;
  logic watch = 0;
  logic synced = 0;
  int failures = 0;
  int comparisons = 0;
  int ph = 0;
  int hit = 0;
  par_word_t exp_q[$];
  par_word_t e;

  display_serializer #(.LOSS_CYCLES(12), .PD_CYCLES(4)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .parallel_clock_in(parallel_clock_in),
    .bit_clk(bit_clk), .parallel_data_in(parallel_data_in),
    .strobe_rising(strobe_rising), .power_down_n(power_down_n),
    .lane_data(lane_data), .lane_data_oe(lane_data_oe),
    .lane_clock(lane_clock), .lane_clock_oe(lane_clock_oe));
  link_receiver u_rx (.bit_clk(bit_clk), .lane_data(lane_data), .lane_clock(lane_clock),
    .lane_clock_oe(lane_clock_oe), .rx_word(rx_word), .rx_valid(rx_valid));

  // Supervisor clock and bit clock
  always #5 ref_clk = ~ref_clk;
  always #2 bit_clk = ~bit_clk;
  // Parallel clock toggles every seven bit clock edges while running
  always @(bit_clk)
  begin
    ph = (ph == 6) ? 0 : ph + 1;
    if (ph == 0 && link_run)
      parallel_clock_in = ~parallel_clock_in;
  end
  // New random word on the edge opposite the capture edge
  always @(parallel_clock_in)
    if (parallel_clock_in != strobe_rising)
    begin
      parallel_data_in = par_word_t'($urandom);
      exp_q.push_back(parallel_data_in);
    end
  // Lock on the first received word found in the queue, then every word must follow in order
  always @(posedge bit_clk)
    if (watch && rx_valid)
    begin
      if (!synced)
      begin
        hit = -1;
        foreach (exp_q[i])
          if (hit < 0 && exp_q[i] === rx_word)
            hit = i;
        if (hit >= 0)
        begin
          repeat (hit)
            void'(exp_q.pop_front());
          synced = 1;
        end
      end
      if (synced)
      begin
        e = exp_q.pop_front();
        `CHK(rx_word, e)
      end
    end

  task wait_ref(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task stream(input int n);
    exp_q.delete();
    synced = 0;
    watch = 1;
    wait_ref(n);
    `CHK(synced, 1'b1)
  endtask

  task wrap_up;
    $display("counts: comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #100000;
    failures++;
    wrap_up;
  end

  // Main sequence
  initial
  begin
    void'($urandom(11525));
    wait_ref(5);
    `CHK({lane_clock_oe, lane_data_oe}, 5'h00)
    reset_n = 1;
    link_run = 0;
    wait_ref(100);
    `CHK({lane_clock_oe, lane_data_oe}, 5'h00)
    $display("test power_down_low done");
    power_down_n = 1;
    wait_ref(40);
    `CHK({lane_clock_oe, lane_data_oe, lane_clock, lane_data}, 10'h3E0)
    $display("test no_clock_low done");
    link_run = 1;
    wait_ref(40);
    stream(300);
    $display("test rising_strobe done");
    watch = 0;
    strobe_rising = 0;
    wait_ref(40);
    stream(300);
    $display("test falling_strobe done");
    power_down_n = 0;
    wait_ref(2);
    power_down_n = 1;
    wait_ref(100);
    `CHK({lane_clock_oe, lane_data_oe}, 5'h1F)
    $display("test short_pulse done");
    watch = 0;
    power_down_n = 0;
    wait_ref(100);
    `CHK({lane_clock_oe, lane_data_oe}, 5'h00)
    link_run = 0;
    wait_ref(10);
    power_down_n = 1;
    wait_ref(60);
    `CHK({lane_clock_oe, lane_data_oe, lane_clock, lane_data}, 10'h3E0)
    strobe_rising = 1;
    link_run = 1;
    wait_ref(40);
    stream(300);
    $display("test late_clock done");
    watch = 0;
    link_run = 0;
    wait_ref(60);
    `CHK({lane_clock_oe, lane_data_oe, lane_clock, lane_data}, 10'h3E0)
    $display("test lost_clock done");
    wrap_up;
  end
endmodule
